// File: src/acrc_pkg.sv
// Purpose: Shared constants and types for the converter clock, rate and
//          conversion timing controller.
// Assumes: APB register map with one register per aligned word, 8 bits wide except the 16-bit status.
// Notes:   All timing is counted in modulator periods of 16 clocks.
`default_nettype none

package acrc_pkg;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int MOD_DIV = 16;
    localparam logic [3:0] PRE_LAST = 4'hF;
    localparam logic [16:0] CFG_DELAY_MODS = 17'hE;
    localparam int CFG_DELAY_CYC = 14 * MOD_DIV;
    localparam logic [16:0] OVH_LONG = 17'h681;
    localparam logic [16:0] OVH_MID = 17'h41;
    localparam logic [16:0] OVH_SHORT = 17'h28;

    // --------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CFG_FIRST = 8'h0C;
    localparam logic [7:0] OFS_RATE = 8'h10;
    localparam logic [7:0] OFS_REF = 8'h14;
    localparam logic [7:0] OFS_CFG_LAST = 8'h1C;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [2:0] CFG_BASE_IDX = 3'h3;
    localparam int CFG_COUNT = 5;

    // --------------------------------------------------------------
    // Field positions and reset values
    // --------------------------------------------------------------
    localparam int RATE_CODE_LSB = 0;
    localparam int RATE_CLK_SEL_BIT = 6;
    localparam int REF_POS_DIS_BIT = 5;
    localparam int REF_NEG_DIS_BIT = 4;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RESET_BIT = 1;
    localparam int CTRL_STOP_BIT = 2;
    localparam int CTRL_SINGLE_BIT = 4;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic CTRL_SINGLE_RST = 1'b0;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CFG = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_OVH = 3'b011,
        ST_RUN = 3'b100
    } acrc_state_e;

    typedef struct packed {
        logic data_ready;
        logic comp_active;
        logic busy;
        acrc_state_e state;
    } acrc_conv_s;

endpackage : acrc_pkg

`default_nettype wire

// File: src/acrc_ctrl.sv
// Purpose: Clock source select, modulator clock divider, rate decode and
//          conversion sequencing for a delta-sigma converter.
// Assumes: clk is the selected system clock; inputs synchronous to clk.
// Notes:   Register access over APB with one wait state.
//
// Summary of operation
// - Reference buffer disable bits are active low enables: one disables.
// - One rate-register bit selects internal oscillator or external clock.
// - Any reset returns clock selection to the internal oscillator.
// - Modulator clock is the system clock divided by sixteen.
// - Data rate is modulator clock over the ratio chosen by rate code.
// - Codes 0000-0110 give ratios 102400 down to 4264.
// - Codes 0111-1101 give ratios 2560 down to 64.
// - New conversion begins with 14 modulator periods of configuration delay.
// - Delay follows start command, start pin rise, config change 03h-07h.
// - Conversion starts on start pin rise or start command.
// - First result takes delay, sampling and overhead periods.
// - Later continuous results follow one data period apart.
// - Offset and gain compensation happen during overhead time.
// - Result is settled after one full data period of sampling.
`timescale 1ns/10ps
`default_nettype none

module acrc_ctrl #(
    parameter int unsigned OVS_SHIFT = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Start/sync pin
    input wire logic start_sync,
    // Converter control
    output logic ext_clk_sel,
    output logic modulator_clock,
    output logic pos_ref_buffer_disable,
    output logic neg_ref_buffer_disable,
    output var acrc_pkg::acrc_conv_s conv_status
);

    if (OVS_SHIFT > 6) begin : g_bad_shift
        $error("OVS_SHIFT above 6 leaves no sampling period");
    end

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic is_cfg(input logic [7:0] addr);
        is_cfg = addr >= acrc_pkg::OFS_CFG_FIRST && addr <= acrc_pkg::OFS_CFG_LAST
            && addr[1:0] == 2'h0;
    endfunction : is_cfg

    function automatic logic [2:0] cfg_idx(input logic [7:0] addr);
        cfg_idx = 3'(addr[4:2] - acrc_pkg::CFG_BASE_IDX);
    endfunction : cfg_idx

    // Reserved codes fall back to the fastest ratio
    function automatic logic [16:0] osr_of(input logic [3:0] code);
        case (code)
            4'h0: osr_of = 17'h19000;
            4'h1: osr_of = 17'h0C800;
            4'h2: osr_of = 17'h06400;
            4'h3: osr_of = 17'h03C00;
            4'h4: osr_of = 17'h03200;
            4'h5: osr_of = 17'h01400;
            4'h6: osr_of = 17'h010A8;
            4'h7: osr_of = 17'h00A00;
            4'h8: osr_of = 17'h00500;
            4'h9: osr_of = 17'h00280;
            4'hA: osr_of = 17'h00140;
            4'hB: osr_of = 17'h00100;
            4'hC: osr_of = 17'h00080;
            default: osr_of = 17'h00040;
        endcase
    endfunction : osr_of

    function automatic logic [16:0] ovh_of(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h4: ovh_of = acrc_pkg::OVH_LONG;
            4'h3, 4'h6: ovh_of = acrc_pkg::OVH_MID;
            default: ovh_of = acrc_pkg::OVH_SHORT;
        endcase
    endfunction : ovh_of

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] cfg_ff [acrc_pkg::CFG_COUNT];
    logic single_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic start_q_ff;
    logic [3:0] pre_ff;
    logic [16:0] cnt_ff;
    logic [31:0] tot_ff;
    logic [7:0] res_cnt_ff;
    acrc_pkg::acrc_state_e state_ff;
    acrc_pkg::acrc_conv_s status_ff;
    acrc_pkg::acrc_state_e nxt_state;
    logic [16:0] nxt_cnt;
    logic setup_acc, acc, addr_ok, wr_acc, wr_ctrl, cfg_wr, cfg_chg;
    logic soft_rst, start_cmd, stop_cmd, start_rise, restart, tick, done;
    logic [3:0] rate_code;
    logic [16:0] osr_raw, osr_s, ovh_v, tgt, first_mods;
    logic [31:0] first_cyc, period_cyc, rd_val;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign conv_status = status_ff;
    assign rate_code = cfg_ff[1][acrc_pkg::RATE_CODE_LSB +: 4];
    assign ext_clk_sel = cfg_ff[1][acrc_pkg::RATE_CLK_SEL_BIT];
    assign pos_ref_buffer_disable = cfg_ff[2][acrc_pkg::REF_POS_DIS_BIT];
    assign neg_ref_buffer_disable = cfg_ff[2][acrc_pkg::REF_NEG_DIS_BIT];
    assign modulator_clock = pre_ff[3];

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign setup_acc = psel && penable && !pready_ff;
    assign acc = psel && penable && pready_ff;
    assign addr_ok = is_cfg(paddr) || paddr == acrc_pkg::OFS_CTRL
        || paddr == acrc_pkg::OFS_STATUS;
    assign wr_acc = acc && pwrite && pstrb[0] && addr_ok;
    assign wr_ctrl = wr_acc && paddr == acrc_pkg::OFS_CTRL;
    assign cfg_wr = wr_acc && is_cfg(paddr);
    assign cfg_chg = cfg_wr && pwdata[7:0] != cfg_ff[cfg_idx(paddr)];
    assign soft_rst = wr_ctrl && pwdata[acrc_pkg::CTRL_RESET_BIT];
    assign start_cmd = wr_ctrl && pwdata[acrc_pkg::CTRL_START_BIT];
    assign stop_cmd = wr_ctrl && pwdata[acrc_pkg::CTRL_STOP_BIT];
    assign start_rise = start_sync && !start_q_ff;
    // restart on start or config change
    assign restart = !soft_rst && (start_cmd || start_rise
        || (cfg_chg && state_ff != acrc_pkg::ST_IDLE));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_acc;
            pslverr_ff <= setup_acc && !addr_ok;
        end
    end

    always_comb begin
        rd_val = 32'h0;
        if (is_cfg(paddr)) begin
            rd_val = {24'h0, cfg_ff[cfg_idx(paddr)]};
        end else if (paddr == acrc_pkg::OFS_CTRL) begin
            rd_val = {27'h0, single_ff, 4'h0};
        end else if (paddr == acrc_pkg::OFS_STATUS) begin
            rd_val = {16'h0, res_cnt_ff, 4'h0, state_ff != acrc_pkg::ST_IDLE, state_ff};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0;
        end else if (setup_acc && !pwrite) begin
            prdata_ff <= rd_val;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // stored selects, cleared by any reset
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            for (int i = 0; i < acrc_pkg::CFG_COUNT; i++) begin
                cfg_ff[i] <= acrc_pkg::CFG_RST;
            end
        end else if (cfg_wr) begin
            cfg_ff[cfg_idx(paddr)] <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            single_ff <= acrc_pkg::CTRL_SINGLE_RST;
        end else if (wr_ctrl) begin
            single_ff <= pwdata[acrc_pkg::CTRL_SINGLE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q_ff <= 1'b0;
        end else begin
            start_q_ff <= start_sync;
        end
    end

    // ----------------------------------------------------------------
    // Modulator clock divider
    // ----------------------------------------------------------------
    // divide by sixteen, realigned at each new start
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst || restart) begin
            pre_ff <= 4'h0;
        end else begin
            pre_ff <= 4'(pre_ff + 4'h1);
        end
    end
    assign tick = pre_ff == acrc_pkg::PRE_LAST;

    // ----------------------------------------------------------------
    // Rate decode and phase lengths
    // ----------------------------------------------------------------
    // ratio table, shortened only by OVS_SHIFT
    assign osr_raw = osr_of(rate_code);
    assign osr_s = 17'(osr_raw >> OVS_SHIFT);
    assign ovh_v = ovh_of(rate_code);

    always_comb begin
        case (state_ff)
            acrc_pkg::ST_CFG: tgt = acrc_pkg::CFG_DELAY_MODS;
            acrc_pkg::ST_OVH: tgt = ovh_v;
            default: tgt = osr_s;
        endcase
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        done = 1'b0;
        if (soft_rst || stop_cmd) begin
            nxt_state = acrc_pkg::ST_IDLE;
            nxt_cnt = 17'h0;
        end else if (restart) begin
            nxt_state = acrc_pkg::ST_CFG;
            nxt_cnt = 17'h0;
        end else if (tick && state_ff != acrc_pkg::ST_IDLE) begin
            if (cnt_ff == 17'(tgt - 17'h1)) begin
                nxt_cnt = 17'h0;
                case (state_ff)
                    acrc_pkg::ST_CFG: nxt_state = acrc_pkg::ST_SAMPLE;
                    acrc_pkg::ST_SAMPLE: nxt_state = acrc_pkg::ST_OVH;
                    acrc_pkg::ST_OVH: begin
                        done = 1'b1;
                        nxt_state = single_ff ? acrc_pkg::ST_IDLE : acrc_pkg::ST_RUN;
                    end
                    acrc_pkg::ST_RUN: begin
                        done = 1'b1;
                    end
                    default: nxt_state = acrc_pkg::ST_IDLE;
                endcase
            end else begin
                nxt_cnt = 17'(cnt_ff + 17'h1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= acrc_pkg::ST_IDLE;
            cnt_ff <= 17'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // compensation flagged for the whole overhead phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_ff <= '{data_ready: 1'b0, comp_active: 1'b0, busy: 1'b0,
                state: acrc_pkg::ST_IDLE};
        end else begin
            status_ff <= '{data_ready: done, comp_active: nxt_state == acrc_pkg::ST_OVH,
                busy: nxt_state != acrc_pkg::ST_IDLE, state: nxt_state};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            res_cnt_ff <= 8'h00;
        end else if (done) begin
            res_cnt_ff <= 8'(res_cnt_ff + 8'h01);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles since the last start or result; read only by the checks
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst || restart || done) begin
            tot_ff <= 32'h0;
        end else begin
            tot_ff <= 32'(tot_ff + 32'h1);
        end
    end
    assign first_mods = 17'(osr_s + ovh_v + acrc_pkg::CFG_DELAY_MODS);
    assign first_cyc = {11'h0, first_mods, 4'h0};
    assign period_cyc = {11'h0, osr_s, 4'h0};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_quiet8;
        (!tick)[*8];
    endsequence
    sequence s_quiet7;
        (!tick)[*7];
    endsequence

    a_ref_buf_pol: assert property (
        cfg_wr && paddr == acrc_pkg::OFS_REF |=> pos_ref_buffer_disable == $past(pwdata[5])
            && neg_ref_buffer_disable == $past(pwdata[4]))
        else $error("reference buffer disable bits wrong");
    a_clk_sel_wr: assert property (
        cfg_wr && paddr == acrc_pkg::OFS_RATE |=> ext_clk_sel == $past(pwdata[6]))
        else $error("clock source select not stored");
    a_clk_sel_rst: assert property (
        soft_rst |=> !ext_clk_sel && state_ff == acrc_pkg::ST_IDLE)
        else $error("reset did not return to internal oscillator");
    a_mod_tick_gap: assert property (
        tick |=> s_quiet8 ##1 s_quiet7)
        else $error("modulator period shorter than sixteen clocks");
    a_osr_slow_code: assert property (
        rate_code == 4'h6 |-> osr_raw == 17'h010A8 && ovh_v == acrc_pkg::OVH_MID)
        else $error("ratio for code 0110 wrong");
    a_osr_fast_code: assert property (
        rate_code == 4'hD |-> osr_raw == 17'h00040)
        else $error("ratio for code 1101 wrong");
    a_cfg_delay_len: assert property (
        state_ff == acrc_pkg::ST_CFG && nxt_state == acrc_pkg::ST_SAMPLE
            |-> tot_ff == 32'(acrc_pkg::CFG_DELAY_CYC - 1))
        else $error("configuration delay not fourteen periods");
    a_cfg_chg_restart: assert property (
        restart |=> state_ff == acrc_pkg::ST_CFG && cnt_ff == 17'h0 && pre_ff == 4'h0)
        else $error("restart did not enter configuration delay");
    a_start_pin_edge: assert property (
        start_rise && !soft_rst |=> state_ff == acrc_pkg::ST_CFG ##223
            state_ff == acrc_pkg::ST_CFG || $past(restart, 1))
        else $error("start pin rise did not start conversion");
    a_first_result_time: assert property (
        done && state_ff == acrc_pkg::ST_OVH |-> tot_ff == 32'(first_cyc - 32'h1)
            ##1 status_ff.data_ready)
        else $error("first result time wrong");
    a_cont_period_len: assert property (
        done && state_ff == acrc_pkg::ST_RUN |-> tot_ff == 32'(period_cyc - 32'h1))
        else $error("continuous data period wrong");
    a_comp_in_ovh: assert property (
        state_ff == acrc_pkg::ST_OVH |-> status_ff.comp_active && status_ff.busy)
        else $error("compensation flag missing in overhead");

endmodule : acrc_ctrl

`default_nettype wire

// File: dv/acrc_host.sv
// Purpose: Host model driving APB transfers and the start/sync pin.
// Assumes: The slave answers every access within 50 cycles.
// Notes:   Signals change only by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module acrc_host (
    // Clock
    input wire logic clk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Start pin
    output logic start_sync
);
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        start_sync = 1'b0;
    end

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic hung);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        hung = (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // ----------------------------------------------------------------
    // Start pin
    // ----------------------------------------------------------------
    // start pin level
    task automatic set_start(input logic lvl);
        @(posedge clk);
        start_sync <= lvl;
    endtask : set_start
endmodule : acrc_host

`default_nettype wire

// File: dv/adc_clock_rate_conversion_timing_bench.sv
// Purpose: Self-checking bench for the clock, rate and conversion timing block.
// Assumes: OVERSAMPLING_RATIO shortened by OVS_SHIFT; overheads stay at full length.
// Notes:   Expected latencies come from the specified first-result totals.
`timescale 1ns/10ps
`default_nettype none

module adc_clock_rate_conversion_timing_bench;
    localparam int SHIFT = 6;
    logic clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, start_sync;
    logic ext_clk_sel, modulator_clock, pos_ref_buffer_disable, neg_ref_buffer_disable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb;
    logic er, hg;
    acrc_pkg::acrc_conv_s conv_status;
    int n_errors, comparisons, oversampling_ratio;
    int regs[8];
    int osr_full[14] = '{102400, 51200, 25600, 15360, 12800, 5120, 4264, 2560, 1280, 640, 320, 256, 128, 64};
    int first_full[14] = '{104079, 52879, 27279, 15439, 14479, 5174, 4343, 2614, 1334, 694, 374, 310, 182, 118};

    acrc_ctrl #(.OVS_SHIFT(SHIFT)) acrc_ctrl_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_sync(start_sync), .ext_clk_sel(ext_clk_sel), .modulator_clock(modulator_clock),
        .pos_ref_buffer_disable(pos_ref_buffer_disable), .neg_ref_buffer_disable(neg_ref_buffer_disable),
        .conv_status(conv_status));
    acrc_host acrc_host_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_sync(start_sync));

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        acrc_host_i.xfer(a, w, d, rd, er, hg);
        if (hg) begin
            n_errors++;
            give_verdict();
        end
        // Let the access edge settle before anything is compared
        #1;
    endtask : xfer

    function automatic int ovh_cyc(input int c);
        return 16 * (first_full[c] - 14 - osr_full[c]);
    endfunction : ovh_cyc

    function automatic int first_lat(input int c);
        return 16 * (14 + (osr_full[c] >> SHIFT)) + ovh_cyc(c);
    endfunction : first_lat

    // Edges from the start edge until a result is flagged, overhead cycles on the way
    task automatic wait_result(input int exp, input int exp_ovh, input string what);
        int n;
        int k;
        n = 0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (conv_status.comp_active === 1'b1) k++;
        end while (conv_status.data_ready !== 1'b1 && n < 60000);
        if (conv_status.data_ready !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
        check(what, 32'(exp), 32'(n));
        check("overhead cycles", 32'(exp_ovh), 32'(k));
    endtask : wait_result

    // Edges from the start edge until the overhead phase begins
    task automatic wait_ovh(input int exp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (conv_status.comp_active !== 1'b1 && n < 20000);
        if (conv_status.comp_active !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
        check("sampling end", 32'(exp), 32'(n));
    endtask : wait_ovh

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        rst_n = 1'b0;
        seed = 32'h798C;
        n_errors = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check("ext_clk_sel", 32'h0, 32'(ext_clk_sel));
        check("conv_status", 32'h0, 32'(conv_status));
        for (int i = 3; i < 8; i++) begin
            regs[i] = 0;
            xfer(8'(i * 4), 1'b0, 32'h0);
            check("cfg reset", 32'h0, rd);
        end
        for (int i = 3; i < 8; i++) begin
            if (i == 3 || i == 6 || i == 7) begin
                seed = lfsr_next(seed);
                regs[i] = int'(seed[7:0]);
                xfer(8'(i * 4), 1'b1, seed);
                xfer(8'(i * 4), 1'b0, 32'h0);
                check("cfg storage", 32'(regs[i]), rd);
            end
        end
        xfer(8'h40, 1'b0, 32'h0);
        check("unmapped err", 32'h1, 32'(er));
        check("unmapped data", 32'h0, rd);
        $display("test registers done");
        // all four combinations of the two reference buffer disable bits
        for (int v = 0; v < 4; v++) begin
            xfer(acrc_pkg::OFS_REF, 1'b1, 32'(v << 4));
            check("pos_ref_buffer_disable", 32'(v >> 1), 32'(pos_ref_buffer_disable));
            check("neg_ref_buffer_disable", 32'(v & 1), 32'(neg_ref_buffer_disable));
        end
        $display("test reference buffers done");
        xfer(acrc_pkg::OFS_RATE, 1'b1, 32'h4D);
        check("ext_clk_sel", 32'h1, 32'(ext_clk_sel));
        xfer(acrc_pkg::OFS_CTRL, 1'b1, 32'h02);
        check("ext_clk_sel", 32'h0, 32'(ext_clk_sel));
        xfer(acrc_pkg::OFS_RATE, 1'b0, 32'h0);
        check("rate after reset", 32'h0, rd);
        xfer(acrc_pkg::OFS_RATE, 1'b1, 32'h40);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check("ext_clk_sel", 32'h0, 32'(ext_clk_sel));
        $display("test clock source done");
        n = 0;
        for (int ph = 0; ph < 4; ph++) begin
            if (ph == 2) n = 0;
            while (modulator_clock !== ph[0] && n < 40) begin
                @(posedge clk);
                #1;
                n++;
            end
        end
        check("modulator period", 32'd16, 32'(n));
        $display("test modulator clock done");
        for (int c = 0; c < 14; c++) begin
            xfer(acrc_pkg::OFS_RATE, 1'b1, 32'(c));
            xfer(acrc_pkg::OFS_CTRL, 1'b1, 32'h11);
            if (c == 1 || c == 2 || c == 4) begin
                // Long overheads: time the sampling phase only, to bound the run
                wait_ovh(16 * (14 + (osr_full[c] >> SHIFT)));
                xfer(acrc_pkg::OFS_CTRL, 1'b1, 32'h04);
                check("stop in overhead", 32'(acrc_pkg::ST_IDLE), 32'(conv_status.state));
            end else begin
                wait_result(first_lat(c), ovh_cyc(c), "first result");
                check("single idle", 32'(acrc_pkg::ST_IDLE), 32'(conv_status.state));
            end
        end
        $display("test rate codes done");
        xfer(acrc_pkg::OFS_CTRL, 1'b1, 32'h00);
        xfer(acrc_pkg::OFS_RATE, 1'b1, 32'h0B);
        oversampling_ratio = osr_full[11] >> SHIFT;
        acrc_host_i.set_start(1'b1);
        @(posedge clk);
        #1;
        check("pin start", 32'(acrc_pkg::ST_CFG), 32'(conv_status.state));
        wait_result(first_lat(11), ovh_cyc(11), "pin first result");
        wait_result(16 * oversampling_ratio, 0, "data period");
        wait_result(16 * oversampling_ratio, 0, "data period");
        check("run state", 32'(acrc_pkg::ST_RUN), 32'(conv_status.state));
        regs[3] = regs[3] ^ 1;
        xfer(acrc_pkg::OFS_CFG_FIRST, 1'b1, 32'(regs[3]));
        #1;
        check("cfg restart", 32'(acrc_pkg::ST_CFG), 32'(conv_status.state));
        wait_result(first_lat(11), ovh_cyc(11), "restart result");
        xfer(acrc_pkg::OFS_CFG_FIRST, 1'b1, 32'(regs[3]));
        #1;
        check("same value", 32'(acrc_pkg::ST_RUN), 32'(conv_status.state));
        xfer(acrc_pkg::OFS_CTRL, 1'b1, 32'h04);
        #1;
        check("stopped", 32'h0, 32'({conv_status.busy, conv_status.state}));
        acrc_host_i.set_start(1'b0);
        $display("test continuous done");
        give_verdict();
    end
endmodule : adc_clock_rate_conversion_timing_bench

`default_nettype wire
